// [common/cmp_ctl_pkg.sv]
// Purpose: Shared constants and types for the analog comparator control block
// Assumes: 8-bit registers on 32-bit APB words, byte addresses 4x register index
// Notes: Register indices are kept as printed; byte address derived from them
package cmp_ctl_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h2c;
  localparam logic [7:0] IDX_INPUT_SEL = 8'h2d;
  localparam logic [7:0] IDX_LADDER = 8'h2e;
  localparam logic [7:0] IDX_PIN_EN = 8'h2f;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL_STATUS = {2'h0, IDX_CTRL_STATUS, 2'h0};
  localparam logic [11:0] ADDR_INPUT_SEL = {2'h0, IDX_INPUT_SEL, 2'h0};
  localparam logic [11:0] ADDR_LADDER = {2'h0, IDX_LADDER, 2'h0};
  localparam logic [11:0] ADDR_PIN_EN = {2'h0, IDX_PIN_EN, 2'h0};
  // Control/status field positions
  localparam int CS_ENABLE_BIT = 7;
  localparam int CS_HYSTERESIS_SELECT_BIT = 6;
  localparam int CS_FLAG_BIT = 5;
  localparam int CS_IRQEN_BIT = 4;
  localparam int CS_OUT_BIT = 3;
  localparam int CS_PINEN_BIT = 2;
  localparam int CS_SENS_LSB = 0;
  // Input select field positions
  localparam int SEL_POS_LSB = 4;
  localparam int SEL_NEG_LSB = 0;
  // Ladder field positions
  localparam int LAD_ENABLE_BIT = 7;
  localparam int LAD_REF_BIT = 6;
  localparam int LAD_CODE_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Writable masks; reserved bits read zero
  localparam logic [7:0] MASK_INPUT_SEL = 8'h33;
  localparam logic [7:0] MASK_PIN_EN = 8'h07;
  // Synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SENS_FALL_A = 2'h0,
    SENS_RISE = 2'h1,
    SENS_FALL_B = 2'h2,
    SENS_BOTH = 2'h3
  } sens_t;

  typedef enum logic [1:0] {
    SRC_EXT0 = 2'h0,
    SRC_EXT1 = 2'h1,
    SRC_RSVD = 2'h2,
    SRC_LADDER = 2'h3
  } src_t;

  // Analog-side controls travelling together
  typedef struct packed {
    logic enable;
    logic hysteresis_select_30mv;
    src_t pos_sel;
    src_t neg_sel;
    logic ladder_enable;
    logic ladder_ref_vdda;
    logic [5:0] ladder_code;
    logic [2:0] input_pin_enable;
  } analog_ctl_t;
endpackage

// [core/cmp_ctl.sv]
// Purpose: APB register file and digital control of an analog comparator
// Assumes: Raw comparator output is asynchronous to CLK
// Notes: Zero-wait-state APB slave, PSLVERR on unmapped addresses
//
// Function
// - Control bit 7 turns the comparator on (1) or off (0).
// - Control bit 6 selects hysteresis, 0 for 20 mV, 1 for 30 mV.
// - Edge flag bit 5 sets synchronously on a selected comparator output edge.
// - Writing 0 clears the edge flag; writing 1 leaves it alone.
// - Bit 4 gates the interrupt request from the edge flag.
// - Bit 3 reads the synchronized comparator output.
// - Output status resets to 0 and reads 0 while disabled.
// - Bit 2 lets the comparator output drive the external pin.
// - Sensitivity 00 and 10 falling, 01 rising, 11 both edges.
// - Logic keeps running in wait mode; interrupt can wake the processor.
// - Logic keeps running in stop3; qualifying edge raises a wake interrupt.
// - Settings survive stop3 exit by interrupt; reset returns reset state.
// - Debug mode does not freeze the logic.
// - Ladder code is 6 bits selecting one of 64 levels.
// - Input mux picks among channels, one being the ladder output.
// - Four 8-bit registers from 2C onward, each resetting to 00h.
// - Input selects decode 00 ext0, 01 ext1, 11 ladder, 10 reserved.
// - Ladder bit 7 enables it; level is code plus one sixty-fourths.
// - Flag and interrupt stay pending until software clears the flag.
`timescale 1ns/10ps
module cmp_ctl
  import cmp_ctl_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cmp_ctl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Analog core
  input wire logic RAW_COMPARATOR_OUTPUT,
  output cmp_ctl_pkg::analog_ctl_t ANALOG_CTL,
  output logic [6:0] LADDER_LEVEL,
  // Pad and interrupt
  output logic OUTPUT_PIN_O,
  output logic OUTPUT_PIN_OE,
  output logic IRQ
);
  import cmp_ctl_pkg::*;

  logic enable_ff;
  logic hysteresis_select_ff;
  logic flag_ff;
  logic irq_en_ff;
  logic pin_en_ff;
  sens_t sens_ff;
  logic [7:0] input_sel_ff;
  logic [7:0] ladder_ff;
  logic [7:0] pin_ctl_ff;
  logic [SYNC_STAGES-1:0] sync_ff;
  logic out_status_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic edge_hit;
  logic wr_access;
  logic rd_access;
  logic lane0;

  // Address decode, shared by read and write paths
  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a, output logic hit);
    hit = 1'b1;
    case (a)
      ADDR_CTRL_STATUS: reg_index = 2'h0;
      ADDR_INPUT_SEL: reg_index = 2'h1;
      ADDR_LADDER: reg_index = 2'h2;
      ADDR_PIN_EN: reg_index = 2'h3;
      default: begin
        reg_index = 2'h0;
        hit = 1'b0;
      end
    endcase
  endfunction

  logic addr_hit;
  logic [1:0] addr_idx;
  always_comb begin
    addr_hit = 1'b0;
    addr_idx = reg_index(PADDR, addr_hit);
  end

  assign wr_access = PSEL && PENABLE && PWRITE && addr_hit;
  assign rd_access = PSEL && PENABLE && !PWRITE;
  // Registers live in byte lane 0 only
  assign lane0 = PSTRB[0];

  // Settings are plain flops on one clock with no sleep gating, so they
  // hold across wait, stop3 and debug; only RST_N clears them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_ff <= 1'b0;
      hysteresis_select_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      pin_en_ff <= 1'b0;
      sens_ff <= SENS_FALL_A;
    end else if (wr_access && lane0 && addr_idx == 2'h0) begin
      enable_ff <= PWDATA[CS_ENABLE_BIT];
      hysteresis_select_ff <= PWDATA[CS_HYSTERESIS_SELECT_BIT];
      irq_en_ff <= PWDATA[CS_IRQEN_BIT];
      pin_en_ff <= PWDATA[CS_PINEN_BIT];
      sens_ff <= sens_t'(PWDATA[CS_SENS_LSB +: 2]);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      input_sel_ff <= RST_REG;
      ladder_ff <= RST_REG;
      pin_ctl_ff <= RST_REG;
    end else if (wr_access && lane0) begin
      if (addr_idx == 2'h1) begin
        input_sel_ff <= PWDATA[7:0] & MASK_INPUT_SEL;
      end
      if (addr_idx == 2'h2) begin
        ladder_ff <= PWDATA[7:0];
      end
      if (addr_idx == 2'h3) begin
        pin_ctl_ff <= PWDATA[7:0] & MASK_PIN_EN;
      end
    end
  end

  // Three-stage synchronizer; edges judged only on the settled stages
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[SYNC_STAGES-2:0], RAW_COMPARATOR_OUTPUT};
    end
  end

  // Status reads 0 while disabled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_status_ff <= 1'b0;
    end else if (!enable_ff) begin
      out_status_ff <= 1'b0;
    end else if (sync_ff[1] == sync_ff[2]) begin
      out_status_ff <= sync_ff[2];
    end
  end

  // Edges on the qualified status so a disable does not fake a fall
  always_comb begin
    edge_hit = 1'b0;
    if (enable_ff && sync_ff[1] == sync_ff[2] && sync_ff[2] != out_status_ff) begin
      case (sens_ff)
        SENS_RISE: edge_hit = sync_ff[2];
        SENS_BOTH: edge_hit = 1'b1;
        SENS_FALL_A, SENS_FALL_B: edge_hit = !sync_ff[2];
        default: edge_hit = 1'b0;
      endcase
    end
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_ff <= 1'b0;
    end else if (edge_hit) begin
      flag_ff <= 1'b1;
    end else if (wr_access && lane0 && addr_idx == 2'h0 && !PWDATA[CS_FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  // Level request; also serves as the wake source in wait and stop3
  assign IRQ = flag_ff && irq_en_ff;

  // Pad driven only when both enabled
  assign OUTPUT_PIN_OE = pin_en_ff && enable_ff;
  assign OUTPUT_PIN_O = OUTPUT_PIN_OE && out_status_ff;

  always_comb begin
    ANALOG_CTL.enable = enable_ff;
    ANALOG_CTL.hysteresis_select_30mv = hysteresis_select_ff;
    ANALOG_CTL.pos_sel = src_t'(input_sel_ff[SEL_POS_LSB +: 2]);
    ANALOG_CTL.neg_sel = src_t'(input_sel_ff[SEL_NEG_LSB +: 2]);
    ANALOG_CTL.ladder_enable = ladder_ff[LAD_ENABLE_BIT];
    ANALOG_CTL.ladder_ref_vdda = ladder_ff[LAD_REF_BIT];
    ANALOG_CTL.ladder_code = ladder_ff[LAD_CODE_LSB +: 6];
    ANALOG_CTL.input_pin_enable = pin_ctl_ff[2:0];
  end

  // Ladder numerator in 64ths: code plus one, zero when off
  assign LADDER_LEVEL = ladder_ff[LAD_ENABLE_BIT] ? ({1'b0, ladder_ff[5:0]} + 7'h01) : 7'h00;

  // Read byte muxed from the register flops
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (addr_idx)
      2'h0: rd_byte = {enable_ff, hysteresis_select_ff, flag_ff, irq_en_ff, out_status_ff, pin_en_ff, sens_ff};
      2'h1: rd_byte = input_sel_ff;
      2'h2: rd_byte = ladder_ff;
      2'h3: rd_byte = pin_ctl_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // Data is captured in setup so it stands stable through the access phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_ff <= (!PWRITE && addr_hit) ? {24'h0, rd_byte} : 32'h0;
      pslverr_ff <= !addr_hit;
    end
  end

  // One-cycle access phase; flag read reflects setup-cycle value
  assign PREADY = 1'b1;
  assign PRDATA = rd_access ? prdata_ff : 32'h0;
  assign PSLVERR = PSEL && PENABLE && pslverr_ff;

  // Flag still up the cycle after it sets absent a control write
  sequence flag_rise_s;
    !flag_ff ##1 flag_ff;
  endsequence

  property flag_holds_p;
    @(posedge CLK) disable iff (!RST_N)
    flag_rise_s ##0 !(wr_access && addr_idx == 2'h0)[*1] |=> flag_ff;
  endproperty
  flag_sticky_a: assert property (flag_holds_p) else $error("edge flag dropped without clear");

  enable_on_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_access && lane0 && addr_idx == 2'h0 |=> enable_ff == $past(PWDATA[CS_ENABLE_BIT]))
    else $error("enable bit not taken from write");

  hysteresis_select_drive_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ANALOG_CTL.hysteresis_select_30mv == hysteresis_select_ff && ANALOG_CTL.enable == enable_ff)
    else $error("hysteresis or enable not driven");

  // Settled edges as the detector sees them
  sequence settle_rise_s;
    enable_ff && !out_status_ff && sens_ff == SENS_RISE ##0 sync_ff[2] && sync_ff[1];
  endsequence

  sequence settle_fall_s;
    enable_ff && out_status_ff && sens_ff != SENS_RISE ##0 !sync_ff[2] && !sync_ff[1];
  endsequence

  sequence both_rise_s;
    enable_ff && !out_status_ff && sens_ff == SENS_BOTH ##0 sync_ff[2] && sync_ff[1];
  endsequence

  rise_sets_a: assert property (@(posedge CLK) disable iff (!RST_N)
    settle_rise_s |=> flag_ff)
    else $error("rising edge missed");

  fall_sets_a: assert property (@(posedge CLK) disable iff (!RST_N)
    settle_fall_s |=> flag_ff)
    else $error("falling edge missed");

  both_rise_a: assert property (@(posedge CLK) disable iff (!RST_N)
    both_rise_s |=> flag_ff)
    else $error("rising edge missed in both mode");

  edge_sets_a: assert property (@(posedge CLK) disable iff (!RST_N)
    edge_hit |=> flag_ff)
    else $error("detected edge did not set flag");

  off_no_edge_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !enable_ff && !flag_ff |=> !flag_ff)
    else $error("flag set while disabled");

  clear_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_access && lane0 && addr_idx == 2'h0 && !PWDATA[CS_FLAG_BIT] && !edge_hit |=> !flag_ff)
    else $error("zero write did not clear flag");

  write_one_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_access && addr_idx == 2'h0 && PWDATA[CS_FLAG_BIT] && !flag_ff && !edge_hit |=> !flag_ff)
    else $error("one write set flag");

  // Interrupt request
  irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ == (flag_ff && irq_en_ff))
    else $error("interrupt gate wrong");

  irq_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !irq_en_ff |-> !IRQ)
    else $error("interrupt raised while masked");

  irq_pending_a: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ && !(wr_access && lane0 && addr_idx == 2'h0) |=> IRQ)
    else $error("interrupt dropped without clear");

  // Output status and synchroniser
  status_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !enable_ff |=> !out_status_ff)
    else $error("status not zero when disabled");

  status_track_a: assert property (@(posedge CLK) disable iff (!RST_N)
    enable_ff && sync_ff[2] && sync_ff[1] ##1 enable_ff |-> out_status_ff)
    else $error("status not following output");

  status_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
    enable_ff && !sync_ff[2] && !sync_ff[1] ##1 enable_ff |-> !out_status_ff)
    else $error("status stuck high");

  sync_chain_a: assert property (@(posedge CLK) disable iff (!RST_N)
    sync_ff[2:1] == $past(sync_ff[1:0]))
    else $error("synchroniser stages skipped");

  // Pad and edge sensitivity
  pin_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !pin_en_ff |-> !OUTPUT_PIN_OE && !OUTPUT_PIN_O)
    else $error("pin driven while disabled");

  pin_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
    pin_en_ff && enable_ff |-> OUTPUT_PIN_OE && OUTPUT_PIN_O == out_status_ff)
    else $error("pin not carrying output");

  fall_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sens_ff == SENS_FALL_B) && !flag_ff && enable_ff && !out_status_ff ##1 out_status_ff |-> !flag_ff)
    else $error("rising edge set flag in falling mode");

  rise_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sens_ff == SENS_RISE) && !flag_ff && enable_ff && out_status_ff ##1 !out_status_ff |-> !flag_ff)
    else $error("falling edge set flag in rising mode");

  // Ladder
  ladder_lvl_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ladder_ff[LAD_ENABLE_BIT] |-> LADDER_LEVEL == {1'b0, ladder_ff[5:0]} + 7'h01)
    else $error("ladder level wrong");

  ladder_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !ladder_ff[LAD_ENABLE_BIT] |-> LADDER_LEVEL == 7'h00)
    else $error("ladder level while off");

  ladder_top_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ladder_ff[LAD_ENABLE_BIT] && ladder_ff[5:0] == 6'h3f |-> LADDER_LEVEL == 7'h40)
    else $error("ladder top level wrong");

  ladder_min_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ladder_ff[LAD_ENABLE_BIT] && ladder_ff[5:0] == 6'h00 |-> LADDER_LEVEL == 7'h01)
    else $error("ladder bottom level wrong");

  // Selects and register access
  sel_rsvd_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (input_sel_ff & ~MASK_INPUT_SEL) == 8'h00)
    else $error("reserved select bits set");

  pos_ladder_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (ANALOG_CTL.pos_sel == SRC_LADDER) == (input_sel_ff[SEL_POS_LSB +: 2] == 2'h3))
    else $error("positive ladder select wrong");

  neg_ladder_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (ANALOG_CTL.neg_sel == SRC_LADDER) == (input_sel_ff[SEL_NEG_LSB +: 2] == 2'h3))
    else $error("negative ladder select wrong");

  pin_mask_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (pin_ctl_ff & ~MASK_PIN_EN) == 8'h00)
    else $error("reserved pin enable bits set");

  strobe_ignored_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_access && !lane0 |=> $stable(input_sel_ff) && $stable(ladder_ff) && $stable(pin_ctl_ff) && $stable(enable_ff))
    else $error("write without lane strobe landed");

  err_unmapped_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PSEL && PENABLE && !addr_hit |-> PSLVERR)
    else $error("unmapped access without error");

  err_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PSEL && PENABLE && PWRITE && !addr_hit |=> $stable(input_sel_ff) && $stable(ladder_ff) && $stable(pin_ctl_ff))
    else $error("unmapped write changed a register");
endmodule // cmp_ctl

// [test/cmp_core_model.sv]
// Purpose: Behavioural stand-in for the analog comparator core
// Assumes: DIFF_POSITIVE is the bench's choice of input difference sign
// Notes: While disabled the output is junk that flips every clock
`timescale 1ns/10ps
module cmp_core_model
  import cmp_ctl_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Controls and stimulus
  input wire cmp_ctl_pkg::analog_ctl_t CTL,
  input wire logic DIFF_POSITIVE,
  // Raw result
  output logic RAW_OUT
);
  logic junk_ff = 1'b0;

  always @(posedge CLK) begin
    junk_ff <= ~junk_ff;
  end

  // Async path so the bench never lines up with the sampling edge
  assign #3 RAW_OUT = CTL.enable ? DIFF_POSITIVE : junk_ff;
endmodule // cmp_core_model

// [test/tb_top.sv]
// Purpose: Self-checking bench for the comparator control block
// Assumes: Zero-wait APB slave, 3-4 edge synchroniser latency
// Notes: Waits of 8 edges cover the synchroniser with margin
`timescale 1ns/10ps
module tb_top;
  import cmp_ctl_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, raw, e;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, pin_o, pin_oe, irq;
  logic [6:0] lad;
  analog_ctl_t actl;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  localparam logic [11:0] REGS [4] = '{ADDR_CTRL_STATUS, ADDR_INPUT_SEL, ADDR_LADDER, ADDR_PIN_EN};

  always #5 clk = ~clk;

  cmp_ctl i_cmp_ctl (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RAW_COMPARATOR_OUTPUT(raw), .ANALOG_CTL(actl), .LADDER_LEVEL(lad), .OUTPUT_PIN_O(pin_o),
    .OUTPUT_PIN_OE(pin_oe), .IRQ(irq));
  cmp_core_model i_cmp_core_model (.CLK(clk), .CTL(actl), .DIFF_POSITIVE(lvl), .RAW_OUT(raw));

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, {24'h0, d}, q, er);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    check(q, {24'h0, x});
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    logic [1:0] m;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rdchk(REGS[i], 8'h00);
    apb(1'b0, 12'h0c0, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 12'h0c0, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    $display("Test reset values done");
    wr(ADDR_INPUT_SEL, 8'hff);
    rdchk(ADDR_INPUT_SEL, 8'h33);
    check({28'h0, actl.pos_sel, actl.neg_sel}, {28'h0, SRC_LADDER, SRC_LADDER});
    wr(ADDR_LADDER, 8'hff);
    check({25'h0, lad}, 32'h40);
    check({31'h0, actl.ladder_ref_vdda}, 32'h1);
    rdchk(ADDR_LADDER, 8'hff);
    wr(ADDR_LADDER, 8'h80);
    check({25'h0, lad}, 32'h01);
    // Ladder switched off until the second-reset test writes it again
    wr(ADDR_LADDER, 8'h00);
    check({25'h0, lad}, 32'h00);
    wr(ADDR_INPUT_SEL, 8'h00);
    wr(ADDR_PIN_EN, 8'hff);
    rdchk(ADDR_PIN_EN, 8'h07);
    check({29'h0, actl.input_pin_enable}, 32'h7);
    pstrb <= 4'he;
    wr(ADDR_PIN_EN, 8'h00);
    pstrb <= 4'hf;
    rdchk(ADDR_PIN_EN, 8'h07);
    wr(ADDR_CTRL_STATUS, 8'hc4);
    check({30'h0, actl.enable, actl.hysteresis_select_30mv}, 32'h3);
    check({31'h0, pin_oe}, 32'h1);
    lvl <= 1'b1;
    settle();
    check({31'h0, pin_o}, 32'h1);
    wr(ADDR_CTRL_STATUS, 8'h80);
    check({30'h0, pin_oe, pin_o}, 32'h0);
    lvl <= 1'b0;
    settle();
    $display("Test controls done");
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(ADDR_CTRL_STATUS, 8'h90 | m);
      lvl <= 1'b1;
      settle();
      rdchk(ADDR_CTRL_STATUS, 8'h98 | m | (m[0] ? 8'h20 : 8'h00));
      check({31'h0, irq}, {31'h0, m[0]});
      wr(ADDR_CTRL_STATUS, 8'hb0 | m);
      rdchk(ADDR_CTRL_STATUS, 8'h98 | m | (m[0] ? 8'h20 : 8'h00));
      wr(ADDR_CTRL_STATUS, 8'h90 | m);
      rdchk(ADDR_CTRL_STATUS, 8'h98 | m);
      lvl <= 1'b0;
      settle();
      rdchk(ADDR_CTRL_STATUS, 8'h90 | m | (m != 2'h1 ? 8'h20 : 8'h00));
    end
    $display("Test edge modes done");
    wr(ADDR_CTRL_STATUS, 8'ha3);
    check({31'h0, irq}, 32'h0);
    rdchk(ADDR_CTRL_STATUS, 8'ha3);
    wr(ADDR_CTRL_STATUS, 8'hb3);
    check({31'h0, irq}, 32'h1);
    $display("Test irq gating done");
    lvl <= 1'b1;
    wr(ADDR_CTRL_STATUS, 8'h00);
    settle();
    rdchk(ADDR_CTRL_STATUS, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h81);
    settle();
    rdchk(ADDR_CTRL_STATUS, 8'ha9);
    $display("Test disable done");
    wr(ADDR_LADDER, 8'h85);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(ADDR_LADDER, 8'h00);
    rdchk(ADDR_CTRL_STATUS, 8'h00);
    $display("Test second reset done");
    report_and_stop();
  end
endmodule // tb_top
